// file: design/edge_ctl_if.sv
`timescale 1ns/100ps
// ========================================================
// one count source: its level, the edge wanted, the tick found
interface edge_ctl_if;
    logic level;
    logic [1:0] edge_sel;
    logic tick;
    modport detector (input level, input edge_sel, output tick);
    modport user (output level, output edge_sel, input tick);
endinterface

// file: design/edge_detect.sv
`timescale 1ns/100ps
// ========================================================
// optional synchroniser plus edge finder on one level
module edge_detect #(
    parameter int SYNC = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // source and selection
    edge_ctl_if.detector src
);
    logic seen;
    logic prev;

    generate
        if (SYNC > 0) begin : g_sync
            logic meta;
            logic stable;
            // two flops; only the second one is looked at
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    meta <= 1'b0;
                    stable <= 1'b0;
                end else begin
                    meta <= src.level;
                    stable <= meta;
                end
            end
            assign seen = stable;
        end else begin : g_direct
            // internal taps are already on this clock
            assign seen = src.level;
        end
    endgenerate

    // previous sample for the edge compare
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b0;
        end else begin
            prev <= seen;
        end
    end

    // code 1x takes both transitions, halving the period
    always_comb begin
        if (src.edge_sel[1]) begin
            src.tick = seen ^ prev;
        end else if (src.edge_sel[0]) begin
            src.tick = prev & ~seen;
        end else begin
            src.tick = seen & ~prev;
        end
    end
endmodule

// file: design/prescaler.sv
`timescale 1ns/100ps
// ========================================================
// free running divider shared by all internal clock taps
module prescaler #(
    parameter int WIDTH = timer_pkg::PRESCALE_W
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // divider state, bit n has period 2^(n+1)
    output logic [WIDTH-1:0] taps
);
    // never stopped, so all channels see one common phase
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            taps <= '0;
        end else begin
            taps <= taps + 1'b1;
        end
    end
endmodule

// file: design/timer_channel_clock_control.sv
`timescale 1ns/100ps
// How it works
// - bits 7:5 pick the counter clear event
// - bits 4:3: rise, fall, or both edges
// - both edges halve the count period
// - phase counting overrides edge selection
// - edge selection valid for divide-by-four or slower
// - undivided clock, cascade ignore edge select
// - bits 2:0 pick channel 4's clock; other channels only store them
// - codes 0,1,2,3,6 give divide 1,4,16,64,1024
// - code 4 pin a, code 5 pin c
// - code 7 counts channel 5 wraps
// - phase counting ignores channel 4 prescaler select
// - one control register per channel, six or three
module timer_channel_clock_control #(
    parameter int NUM_CH = timer_pkg::MAX_CH,
    parameter int COUNT_W = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // count sources
    input wire logic ext_count_clock_a,
    input wire logic ext_count_clock_c,
    input wire logic channel5_wrap,
    input wire logic [7:0] clear_events,
    // channel state
    output logic [8*timer_pkg::MAX_CH-1:0] channel_controls,
    output logic count_tick,
    output logic [COUNT_W-1:0] channel_counter
);
    localparam int CH4 = timer_pkg::CASCADE_CH;

    logic [7:0] timer_channel_control [NUM_CH];
    logic [NUM_CH-1:0] run;
    logic [NUM_CH-1:0] phase_mode;
    logic [timer_pkg::PRESCALE_W-1:0] taps;
    logic [2:0] src_sel;
    logic [1:0] edge_sel;
    logic [2:0] clr_sel;
    logic run4;
    logic phase4;
    logic tap_level;
    logic next_tick;
    logic clr_hit;
    logic setup;
    logic done;
    logic [2:0] word;
    logic mapped;
    logic [31:0] next_rdata;

    // ========================================================
    // bus decode
    assign setup = psel & ~penable;
    assign done = psel & penable & pready;
    assign word = paddr[4:2];

    // indices past the channel count are holes, as is the top range
    // channel count bound
    always_comb begin
        mapped = (paddr[1:0] == 2'h0) && (paddr[7:5] == 3'h0);
        if (word < 3'(timer_pkg::MAX_CH)) begin
            mapped = mapped && (word < 3'(NUM_CH));
        end
    end

    // read mux, unused bits read as zero
    always_comb begin
        next_rdata = 32'h0;
        if (paddr == timer_pkg::ADDR_RUN) begin
            next_rdata[timer_pkg::RUN_LSB +: NUM_CH] = run;
            next_rdata[timer_pkg::PHASE_LSB +: NUM_CH] = phase_mode;
        end else if (paddr == timer_pkg::ADDR_COUNT4) begin
            next_rdata[COUNT_W-1:0] = channel_counter;
        end else if (mapped) begin
            next_rdata[7:0] = timer_channel_control[word];
        end
    end

    // answer is prepared in setup so every output is a flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            prdata <= setup ? next_rdata : 32'h0;
        end
    end

    // ========================================================
    // control registers, one per channel
    // no guard against writes while counting
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ctrl
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    timer_channel_control[gi] <= timer_pkg::CTRL_RESET;
                end else if (done && pwrite && mapped
                             && word == 3'(gi)) begin
                    timer_channel_control[gi] <= pwdata[7:0];
                end
            end
            assign channel_controls[8*gi +: 8] = timer_channel_control[gi];
        end
        for (gi = NUM_CH; gi < timer_pkg::MAX_CH; gi++) begin : g_absent
            assign channel_controls[8*gi +: 8] = 8'h00;
        end
    endgenerate

    // run and phase mode bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            run <= '0;
            phase_mode <= '0;
        end else if (done && pwrite && paddr == timer_pkg::ADDR_RUN) begin
            run <= pwdata[timer_pkg::RUN_LSB +: NUM_CH];
            phase_mode <= pwdata[timer_pkg::PHASE_LSB +: NUM_CH];
        end
    end

    // ========================================================
    // channel 4 field split; reduced variant has no channel 4
    generate
        if (NUM_CH > CH4) begin : g_ch4
            assign src_sel = timer_channel_control[CH4][
                timer_pkg::PSC_MSB:timer_pkg::PSC_LSB];
            assign edge_sel = timer_channel_control[CH4][
                timer_pkg::EDGE_MSB:timer_pkg::EDGE_LSB];
            assign clr_sel = timer_channel_control[CH4][
                timer_pkg::CLR_MSB:timer_pkg::CLR_LSB];
            assign run4 = run[CH4];
            assign phase4 = phase_mode[CH4];
        end else begin : g_no_ch4
            assign src_sel = timer_pkg::SRC_DIV1;
            assign edge_sel = timer_pkg::EDGE_RISE;
            assign clr_sel = 3'h0;
            assign run4 = 1'b0;
            assign phase4 = 1'b0;
        end
    endgenerate

    prescaler #(
        .WIDTH(timer_pkg::PRESCALE_W)
    ) u_prescaler (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .taps(taps)
    );

    // tap select; switching taps may fake an edge, hence halted
    // divider taps
    always_comb begin
        case (src_sel)
            timer_pkg::SRC_DIV4: tap_level = taps[timer_pkg::TAP_DIV4];
            timer_pkg::SRC_DIV16: tap_level = taps[timer_pkg::TAP_DIV16];
            timer_pkg::SRC_DIV64: tap_level = taps[timer_pkg::TAP_DIV64];
            timer_pkg::SRC_DIV1024: tap_level = taps[timer_pkg::TAP_DIV1024];
            default: tap_level = 1'b0;
        endcase
    end

    edge_ctl_if int_src ();
    edge_ctl_if pin_a ();
    edge_ctl_if pin_c ();

    assign int_src.level = tap_level;
    assign int_src.edge_sel = edge_sel;
    assign pin_a.level = ext_count_clock_a;
    assign pin_a.edge_sel = edge_sel;
    assign pin_c.level = ext_count_clock_c;
    assign pin_c.edge_sel = edge_sel;

    edge_detect #(
        .SYNC(0)
    ) u_int_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .src(int_src)
    );

    edge_detect #(
        .SYNC(timer_pkg::EXT_SYNC_STAGES)
    ) u_pin_a_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .src(pin_a)
    );

    edge_detect #(
        .SYNC(timer_pkg::EXT_SYNC_STAGES)
    ) u_pin_c_edge (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .src(pin_c)
    );

    // ========================================================
    // count enable for channel 4
    // phase mode mutes every source
    always_comb begin
        next_tick = 1'b0;
        if (run4 && !phase4) begin
            case (src_sel)
                timer_pkg::SRC_DIV1: next_tick = 1'b1;
                timer_pkg::SRC_EXT_A: next_tick = pin_a.tick;
                timer_pkg::SRC_EXT_C: next_tick = pin_c.tick;
                timer_pkg::SRC_CASCADE: next_tick = channel5_wrap;
                default: next_tick = int_src.tick;
            endcase
        end
    end

    assign clr_hit = (clr_sel != 3'h0) && clear_events[clr_sel];

    // clear beats a count in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_tick <= 1'b0;
            channel_counter <= '0;
        end else begin
            count_tick <= next_tick;
            if (clr_hit) begin
                channel_counter <= '0;
            end else if (count_tick) begin
                channel_counter <= channel_counter + 1'b1;
            end
        end
    end

    // ========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic live;
    assign live = run4 && !phase4;

    AST_CLEAR_WINS: assert property (
        clr_hit |=> channel_counter == '0)
        else $error("clear event did not zero the counter");
    AST_DIV4_BOTH: assert property (
        count_tick && live && src_sel == timer_pkg::SRC_DIV4
        && edge_sel[1] ##1 live && $stable(src_sel) && $stable(edge_sel)
        |-> !count_tick ##1 count_tick)
        else $error("both edges on div4 did not tick every two");
    AST_DIV4_RISE: assert property (
        count_tick && live && src_sel == timer_pkg::SRC_DIV4
        && edge_sel == timer_pkg::EDGE_RISE
        |=> !count_tick [*3])
        else $error("rising div4 ticked faster than every four");
    AST_PHASE_MUTE: assert property (
        phase4 |=> !count_tick)
        else $error("counted while phase mode active");
    AST_DIV1: assert property (
        live && src_sel == timer_pkg::SRC_DIV1 |=> count_tick)
        else $error("undivided clock missed a tick");
    AST_CASCADE: assert property (
        live && src_sel == timer_pkg::SRC_CASCADE
        |=> count_tick == $past(channel5_wrap))
        else $error("cascade tick does not follow channel 5 wrap");
    AST_PIN_A: assert property (
        $rose(ext_count_clock_a) && live && src_sel == timer_pkg::SRC_EXT_A
        && edge_sel == timer_pkg::EDGE_RISE ##1 live ##1 live
        |=> count_tick)
        else $error("pin a rising edge not counted");
    AST_ADVANCE: assert property (
        count_tick && !clr_hit
        |=> channel_counter == $past(channel_counter) + 1'b1)
        else $error("counter did not advance on tick");
    AST_CTRL_WRITE: assert property (
        done && pwrite && mapped && word < 3'(NUM_CH)
        |=> timer_channel_control[$past(word)] == $past(pwdata[7:0]))
        else $error("control write not stored");
    AST_MAP_ERR: assert property (
        setup && !mapped |=> pready && pslverr)
        else $error("hole in the map answered without error");

    COV_CASCADE: cover property (
        live && src_sel == timer_pkg::SRC_CASCADE && count_tick);
    COV_PIN_C: cover property (
        live && src_sel == timer_pkg::SRC_EXT_C && count_tick);
    COV_CLEAR: cover property (clr_hit && count_tick);
endmodule

// file: design/timer_pkg.sv
package timer_pkg;
    // ========================================================
    // register map, byte addresses on the APB side
    localparam logic [7:0] ADDR_CTRL_BASE = 8'h00;
    localparam logic [7:0] ADDR_RUN = 8'h18;
    localparam logic [7:0] ADDR_COUNT4 = 8'h1c;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int MAX_CH = 6;
    localparam int CASCADE_CH = 4;
    // ========================================================
    // control register fields
    localparam int CLR_MSB = 7;
    localparam int CLR_LSB = 5;
    localparam int EDGE_MSB = 4;
    localparam int EDGE_LSB = 3;
    localparam int PSC_MSB = 2;
    localparam int PSC_LSB = 0;
    // run register fields: run bits low, phase mode bits high
    localparam int RUN_LSB = 0;
    localparam int PHASE_LSB = 8;
    // ========================================================
    // edge select codes
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    // channel 4 clock source codes
    localparam logic [2:0] SRC_DIV1 = 3'h0;
    localparam logic [2:0] SRC_DIV4 = 3'h1;
    localparam logic [2:0] SRC_DIV16 = 3'h2;
    localparam logic [2:0] SRC_DIV64 = 3'h3;
    localparam logic [2:0] SRC_EXT_A = 3'h4;
    localparam logic [2:0] SRC_EXT_C = 3'h5;
    localparam logic [2:0] SRC_DIV1024 = 3'h6;
    localparam logic [2:0] SRC_CASCADE = 3'h7;
    // ========================================================
    // prescaler: a tap bit n toggles every 2^n cycles, period 2^(n+1)
    localparam int PRESCALE_W = 10;
    localparam int TAP_DIV4 = 1;
    localparam int TAP_DIV16 = 3;
    localparam int TAP_DIV64 = 5;
    localparam int TAP_DIV1024 = 9;
    localparam int EXT_SYNC_STAGES = 2;
endpackage

// file: tb/ext_source_model.sv
`timescale 1ns/100ps
// ========================================================
// far side: two count pins and channel 5 wrap pulses
module ext_source_model #(
    parameter int HALF_A = 8,
    parameter int HALF_C = 4,
    parameter int WRAP_GAP = 5
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // pins and neighbour channel
    output logic ext_count_clock_a,
    output logic ext_count_clock_c,
    output logic channel5_wrap
);
    int cnt_a;
    int cnt_c;
    int cnt_w;
    // pins run free; the block has to sync them itself
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_a <= 0;
            cnt_c <= 0;
            ext_count_clock_a <= 1'b0;
            ext_count_clock_c <= 1'b0;
        end else begin
            cnt_a <= (cnt_a == HALF_A - 1) ? 0 : cnt_a + 1;
            cnt_c <= (cnt_c == HALF_C - 1) ? 0 : cnt_c + 1;
            if (cnt_a == HALF_A - 1) begin
                ext_count_clock_a <= ~ext_count_clock_a;
            end
            if (cnt_c == HALF_C - 1) begin
                ext_count_clock_c <= ~ext_count_clock_c;
            end
        end
    end
    // one-cycle wrap pulse every WRAP_GAP cycles
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_w <= 0;
            channel5_wrap <= 1'b0;
        end else begin
            cnt_w <= (cnt_w == WRAP_GAP - 1) ? 0 : cnt_w + 1;
            channel5_wrap <= (cnt_w == WRAP_GAP - 1);
        end
    end
endmodule

// file: tb/timer_channel_clock_control_tb.sv
`timescale 1ns/100ps
module timer_channel_clock_control_tb;
    localparam logic [1:0] rise_e = timer_pkg::EDGE_RISE;
    localparam logic [1:0] fall_e = timer_pkg::EDGE_FALL;
    localparam logic [1:0] both_e = timer_pkg::EDGE_BOTH;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ext_a;
    logic ext_c;
    logic wrap;
    logic [7:0] clear_events = 8'h00;
    logic [8*timer_pkg::MAX_CH-1:0] controls;
    logic tick;
    logic [15:0] counter;
    logic [31:0] rdat;
    logic rerr;
    logic [31:0] phase_run = 32'h0;
    int err_total = 0;
    int n_checks = 0;

    timer_channel_clock_control i_dut (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .ext_count_clock_a(ext_a), .ext_count_clock_c(ext_c),
        .channel5_wrap(wrap), .clear_events(clear_events),
        .channel_controls(controls), .count_tick(tick),
        .channel_counter(counter)
    );
    ext_source_model i_far (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .ext_count_clock_a(ext_a), .ext_count_clock_c(ext_c),
        .channel5_wrap(wrap)
    );

    always #50 clk_sys = ~clk_sys;

    // ========================================================
    // bus and compare helpers
    // one idle edge after each transfer keeps drives apart
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge clk_sys);
        end
        if (n == 16) begin
            err_total++;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, exp);
            err_total++;
        end
    endtask
    // one count of slack: prescaler phase is not tied to writes
    task automatic near(input logic [15:0] got, input int exp);
        n_checks++;
        if ($isunknown(got) || got > exp + 1 || got + 1 < exp) begin
            $display("CHECK FAILED at %0t: got %h expected %h",
                     $time, got, 16'(exp));
            err_total++;
        end
    endtask
    task automatic measure(input logic [1:0] e, input logic [2:0] s,
                           input int cycles, input int exp);
        logic [15:0] c0;
        apb(1'b1, timer_pkg::ADDR_RUN, 32'h0);
        apb(1'b1, 8'h10, {24'h0, 3'h0, e, s});
        apb(1'b1, timer_pkg::ADDR_RUN, 32'h10 | phase_run);
        apb(1'b0, timer_pkg::ADDR_COUNT4, 32'h0);
        c0 = rdat[15:0];
        repeat (cycles - 3) @(posedge clk_sys);
        apb(1'b0, timer_pkg::ADDR_COUNT4, 32'h0);
        near(rdat[15:0] - c0, exp);
    endtask

    // ========================================================
    // scenarios
    // controls, run word and counter all read zero out of reset
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rdat, 32'h0);
        end
        apb(1'b1, 8'h20, 32'hff);
        chk({31'h0, rerr}, 32'h1);
        // misaligned write is refused and must not land
        apb(1'b1, 8'h11, 32'hff);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk(rdat, 32'h0);
    endtask
    task automatic t_regs();
        for (int i = 0; i < 6; i++) begin
            logic [7:0] p;
            p = 8'(8'h5a + i * 37);
            apb(1'b1, 8'(4 * i), {24'h0, p});
            apb(1'b0, 8'(4 * i), 32'h0);
            chk(rdat, {24'h0, p});
            chk({31'h0, rerr}, 32'h0);
            chk({24'h0, controls[8*i +: 8]}, {24'h0, p});
        end
        chk({24'h0, controls[7:0]}, 32'h5a);
    endtask
    // clear select 2: event 1 must not clear, event 2 must
    task automatic t_clear();
        apb(1'b1, timer_pkg::ADDR_RUN, 32'h0);
        apb(1'b1, 8'h10, 32'h40);
        apb(1'b1, timer_pkg::ADDR_RUN, 32'h10);
        repeat (40) @(posedge clk_sys);
        chk({31'h0, tick}, 32'h1);
        clear_events <= 8'h02;
        @(posedge clk_sys);
        clear_events <= 8'h00;
        apb(1'b0, timer_pkg::ADDR_COUNT4, 32'h0);
        chk({31'h0, rdat[15:0] > 16'd16}, 32'h1);
        clear_events <= 8'h04;
        @(posedge clk_sys);
        clear_events <= 8'h00;
        apb(1'b0, timer_pkg::ADDR_COUNT4, 32'h0);
        chk({31'h0, rdat[15:0] < 16'd6}, 32'h1);
    endtask
    // far side: pin a period 16, pin c edge every 4, wrap every 5
    task automatic t_rates();
        measure(rise_e, timer_pkg::SRC_DIV1, 64, 64);
        measure(both_e, timer_pkg::SRC_DIV1, 64, 64);
        measure(rise_e, timer_pkg::SRC_DIV4, 256, 64);
        measure(fall_e, timer_pkg::SRC_DIV4, 256, 64);
        measure(both_e, timer_pkg::SRC_DIV4, 256, 128);
        measure(both_e, timer_pkg::SRC_DIV16, 256, 32);
        measure(rise_e, timer_pkg::SRC_DIV64, 1024, 16);
        measure(rise_e, timer_pkg::SRC_DIV1024, 2048, 2);
        measure(rise_e, timer_pkg::SRC_EXT_A, 256, 16);
        measure(both_e, timer_pkg::SRC_EXT_C, 256, 64);
        measure(fall_e, timer_pkg::SRC_CASCADE, 255, 51);
        phase_run = 32'h1000;
        measure(rise_e, timer_pkg::SRC_DIV1, 64, 0);
        measure(rise_e, timer_pkg::SRC_CASCADE, 255, 0);
        chk({31'h0, tick}, 32'h0);
        phase_run = 32'h0;
    endtask

    // ========================================================
    // sequence, watchdog and verdict
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_regs();
        t_clear();
        t_rates();
        finish_test();
    end
    // run needs about 6000 cycles; this is a generous ceiling
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        finish_test();
    end
endmodule
